// >>> rtl/rofm_regs.svh
// Purpose: Offsets, field positions and counts of the rail override regs
// Assumes: Eight-bit register access port inside the device
// Notes:   Definitions only
`ifndef ROFM_REGS_SVH
`define ROFM_REGS_SVH
`define ROFM_ADDR_OVERRIDE    8'hA1
`define ROFM_ADDR_FAULT_MASK  8'hA2
`define ROFM_LVL_LSB          4
`define ROFM_NUM_OUT          4
`define ROFM_NUM_RAIL         4
`define ROFM_NUM_FAULT        8
`define ROFM_BIT_TERM         3
`define ROFM_BIT_SHARED       2
`define ROFM_BIT_LOAD_SWITCH_B_ONE         1
`define ROFM_BIT_AUX3         0
`define ROFM_ZERO8            8'h00
`endif

// >>> rtl/rofm_pkg.sv
// Purpose: Types shared by the rail override and fault mask block
// Assumes: rofm_regs.svh holds all numbers
// Notes:   Factory image carried as one packed struct
package rofm_pkg;
	// Factory configuration store image, loaded after power-on reset
	typedef struct packed {
		logic [7:0] override_reset;
		logic [7:0] fault_mask_reset;
		logic [3:0] pin_host_ctrl;
		logic [3:0] pin_push_pull;
		logic       shared_is_load_switch_b_two;
	} rofm_factory_type;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rofm_req_type;

	typedef enum logic [0:0] {
		ROFM_LOADING,
		ROFM_RUNNING
	} rofm_state_type;
endpackage

// >>> rtl/rofm_rail_override.sv
// Purpose: Output-level/force-on register and first fault mask register
// Assumes: Register port is in the ref_clk domain; pins are asynchronous
// Notes:   Reset values come from the factory store after reset release
`timescale 1ns/10ps
`include "rofm_regs.svh"

// Behaviour
// - Host-controlled output pin follows its level bit; bits 7..4 serve pins 4..1.
// - Pins one to three open-drain or push-pull; pin four open-drain only.
// - Pin driven by power-good tree ignores level bit; bit defaults to 0.
// - Bit 3 forces termination regulator on unless its kill bit is 0.
// - Bit 2 forces shared slot rail on unless shared kill bit is 0.
// - Bit 1 forces load switch B one on unless its kill bit is 0.
// - Bit 0 forces auxiliary regulator three on unless its kill is 0.
// - Fault mask bits 7 and 6 at 1 stop shutdown on those rails.
// - Fault mask bits 5..0 cover step-down six..one; 1 ignores fault.
// - Override register at offset A1h, all bits read and write.
// - Fault mask register at offset A2h, all bits read and write.
// - Kill bit at 0 turns rail off, taking priority over force-on.
module rofm_rail_override
	import rofm_pkg::*;
(
	input  wire logic             ref_clk,
	input  wire logic             arst_n,
	input  wire rofm_factory_type factory_cfg,
	input  wire logic             factory_valid,
	input  wire rofm_req_type     reg_req,
	output logic [7:0]            reg_rdata,
	output logic                  reg_ready,
	input  wire logic [3:0]       pg_tree_level,
	input  wire logic [3:0]       pin_rail_request,
	input  wire logic [3:0]       rail_kill_n,
	input  wire logic [7:0]       rail_fault,
	output logic [3:0]            out_pin_o,
	output logic [3:0]            out_pin_oe,
	output logic [3:0]            rail_enable,
	output logic                  fault_shutdown
);
	rofm_state_type   state_q, state_d;
	rofm_factory_type cfg_q, cfg_d;
	logic [7:0]       override_q, override_d;
	logic [7:0]       fault_mask_q, fault_mask_d;
	logic [7:0]       rdata_q, rdata_d;
	logic             ready_q, ready_d;
	logic [3:0]       pin_o_q, pin_o_d;
	logic [3:0]       pin_oe_q, pin_oe_d;
	logic [3:0]       rail_en_q, rail_en_d;
	logic             shutdown_q, shutdown_d;
	logic [3:0]       pg_s1_q, pg_s2_q;
	logic [3:0]       req_s1_q, req_s2_q;
	logic [3:0]       kill_s1_q, kill_s2_q;
	logic [7:0]       flt_s1_q, flt_s2_q;
	logic             fv_s1_q, fv_s2_q;
	logic [3:0]       level;

	// Same decode serves reads and writes of both registers
	function automatic logic addr_hit(input logic [7:0] a,
		input logic [7:0] target);
		addr_hit = (a == target);
	endfunction

	// Pins, kills and faults come from other domains
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pg_s1_q   <= 4'h0;
			pg_s2_q   <= 4'h0;
			req_s1_q  <= 4'h0;
			req_s2_q  <= 4'h0;
			kill_s1_q <= 4'h0;
			kill_s2_q <= 4'h0;
			flt_s1_q  <= `ROFM_ZERO8;
			flt_s2_q  <= `ROFM_ZERO8;
			fv_s1_q   <= 1'b0;
			fv_s2_q   <= 1'b0;
		end else begin
			pg_s1_q   <= pg_tree_level;
			pg_s2_q   <= pg_s1_q;
			req_s1_q  <= pin_rail_request;
			req_s2_q  <= req_s1_q;
			kill_s1_q <= rail_kill_n;
			kill_s2_q <= kill_s1_q;
			flt_s1_q  <= rail_fault;
			flt_s2_q  <= flt_s1_q;
			fv_s1_q   <= factory_valid;
			fv_s2_q   <= fv_s1_q;
		end
	end

	always_comb begin
		state_d      = state_q;
		cfg_d        = cfg_q;
		override_d   = override_q;
		fault_mask_d = fault_mask_q;
		rdata_d      = rdata_q;
		ready_d      = 1'b0;
		unique case (state_q)
			ROFM_LOADING: begin
				// Strapped image taken only once it is stable
				if (fv_s2_q) begin
					cfg_d        = factory_cfg;
					override_d   = factory_cfg.override_reset;
					fault_mask_d = factory_cfg.fault_mask_reset;
					// Tree-driven pins load their level bits as 0
					for (int i = 0; i < `ROFM_NUM_OUT; i++) begin
						if (!factory_cfg.pin_host_ctrl[i]) begin
							override_d[`ROFM_LVL_LSB + i] = 1'b0;
						end
					end
					state_d = ROFM_RUNNING;
				end
			end
			ROFM_RUNNING: begin
				if (reg_req.wr) begin
					ready_d = 1'b1;
					if (addr_hit(reg_req.addr, `ROFM_ADDR_OVERRIDE)) begin
						override_d = reg_req.wdata;
					end
					if (addr_hit(reg_req.addr, `ROFM_ADDR_FAULT_MASK)) begin
						fault_mask_d = reg_req.wdata;
					end
				end else if (reg_req.rd) begin
					ready_d = 1'b1;
					if (addr_hit(reg_req.addr, `ROFM_ADDR_OVERRIDE)) begin
						rdata_d = override_q;
					end else if (addr_hit(reg_req.addr,
						`ROFM_ADDR_FAULT_MASK)) begin
						rdata_d = fault_mask_q;
					end else begin
						rdata_d = `ROFM_ZERO8;
					end
				end
			end
		endcase
	end

	// Host level bits, one per output pin
	logic out_pin_one_level;
	logic out_pin_two_level;
	logic out_pin_three_level;
	logic out_pin_four_level;

	assign {out_pin_four_level, out_pin_three_level, out_pin_two_level,
		out_pin_one_level} =
		override_q[`ROFM_LVL_LSB +: `ROFM_NUM_OUT];
	assign level = {out_pin_four_level, out_pin_three_level,
		out_pin_two_level, out_pin_one_level};

	// Output pins: level bit or power-good tree
	always_comb begin
		pin_o_d  = 4'h0;
		pin_oe_d = 4'h0;
		for (int i = 0; i < `ROFM_NUM_OUT; i++) begin
			logic drive;
			logic push_pull;
			drive     = cfg_q.pin_host_ctrl[i] ? level[i] : pg_s2_q[i];
			// Pin four has no push-pull stage
			push_pull = cfg_q.pin_push_pull[i] && (i != `ROFM_NUM_OUT - 1);
			if (state_q == ROFM_LOADING) begin
				pin_o_d[i]  = 1'b0;
				pin_oe_d[i] = 1'b0;
			end else if (push_pull) begin
				pin_o_d[i]  = drive;
				pin_oe_d[i] = 1'b1;
			end else begin
				// Open drain: drive low only, release for high
				pin_o_d[i]  = 1'b0;
				pin_oe_d[i] = !drive;
			end
		end
	end

	// Kill beats force-on; force-on or the pin request turns the rail on
	function automatic logic rail_on(input logic force_on,
		input logic pin_req, input logic kill_n);
		rail_on = kill_n && (force_on || pin_req);
	endfunction

	// Force-on fields of the override register
	logic termination_force_on;
	logic shared_slot_force_on;
	logic switch_b_one_force_on;
	logic aux_three_force_on;
	// Synchronised kill inputs, low turns the rail off
	logic termination_kill_n;
	logic shared_slot_kill_n;
	logic switch_b_one_kill_n;
	logic aux_three_kill_n;

	assign termination_force_on  = override_q[`ROFM_BIT_TERM];
	assign shared_slot_force_on  = override_q[`ROFM_BIT_SHARED];
	assign switch_b_one_force_on = override_q[`ROFM_BIT_LOAD_SWITCH_B_ONE];
	assign aux_three_force_on    = override_q[`ROFM_BIT_AUX3];
	assign termination_kill_n    = kill_s2_q[`ROFM_BIT_TERM];
	assign shared_slot_kill_n    = kill_s2_q[`ROFM_BIT_SHARED];
	assign switch_b_one_kill_n   = kill_s2_q[`ROFM_BIT_LOAD_SWITCH_B_ONE];
	assign aux_three_kill_n      = kill_s2_q[`ROFM_BIT_AUX3];

	// Shared slot is one enable whichever rail the image assigns it to
	always_comb begin
		rail_en_d = 4'h0;
		if (state_q == ROFM_RUNNING) begin
			rail_en_d[`ROFM_BIT_TERM] = rail_on(termination_force_on,
				req_s2_q[`ROFM_BIT_TERM],
				termination_kill_n);
			rail_en_d[`ROFM_BIT_SHARED] = rail_on(shared_slot_force_on,
				req_s2_q[`ROFM_BIT_SHARED],
				shared_slot_kill_n);
			rail_en_d[`ROFM_BIT_LOAD_SWITCH_B_ONE] = rail_on(switch_b_one_force_on,
				req_s2_q[`ROFM_BIT_LOAD_SWITCH_B_ONE],
				switch_b_one_kill_n);
			rail_en_d[`ROFM_BIT_AUX3] = rail_on(aux_three_force_on,
				req_s2_q[`ROFM_BIT_AUX3],
				aux_three_kill_n);
		end
	end

	// Fault ignore fields of the mask register
	logic aux_two_fault_ignore;
	logic switch_a_one_fault_ignore;
	logic step_down_six_fault_ignore;
	logic step_down_five_fault_ignore;
	logic step_down_four_fault_ignore;
	logic step_down_three_fault_ignore;
	logic step_down_two_fault_ignore;
	logic step_down_one_fault_ignore;
	logic [7:0] fault_ignore;

	assign {aux_two_fault_ignore, switch_a_one_fault_ignore,
		step_down_six_fault_ignore, step_down_five_fault_ignore,
		step_down_four_fault_ignore, step_down_three_fault_ignore,
		step_down_two_fault_ignore,
		step_down_one_fault_ignore} = fault_mask_q;
	assign fault_ignore = {aux_two_fault_ignore,
		switch_a_one_fault_ignore,
		step_down_six_fault_ignore, step_down_five_fault_ignore,
		step_down_four_fault_ignore, step_down_three_fault_ignore,
		step_down_two_fault_ignore, step_down_one_fault_ignore};

	// Any unmasked fault requests shutdown; none while loading
	always_comb begin
		shutdown_d = (state_q == ROFM_RUNNING) &&
			|(flt_s2_q & ~fault_ignore);
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q      <= ROFM_LOADING;
			cfg_q        <= '0;
			override_q   <= `ROFM_ZERO8;
			fault_mask_q <= `ROFM_ZERO8;
			rdata_q      <= `ROFM_ZERO8;
			ready_q      <= 1'b0;
			pin_o_q      <= 4'h0;
			pin_oe_q     <= 4'h0;
			rail_en_q    <= 4'h0;
			shutdown_q   <= 1'b0;
		end else begin
			state_q      <= state_d;
			cfg_q        <= cfg_d;
			override_q   <= override_d;
			fault_mask_q <= fault_mask_d;
			rdata_q      <= rdata_d;
			ready_q      <= ready_d;
			pin_o_q      <= pin_o_d;
			pin_oe_q     <= pin_oe_d;
			rail_en_q    <= rail_en_d;
			shutdown_q   <= shutdown_d;
		end
	end

	assign reg_rdata      = rdata_q;
	assign reg_ready      = ready_q;
	assign out_pin_o      = pin_o_q;
	assign out_pin_oe     = pin_oe_q;
	assign rail_enable    = rail_en_q;
	assign fault_shutdown = shutdown_q;
endmodule // rofm_rail_override

// >>> test/rofm_factory_model.sv
// Purpose: Factory store model feeding the rail override block
// Assumes: Image is fixed; valid rises 15 cycles after reset
// Notes:   Pin four is tree driven, pins one and three push-pull
`timescale 1ns/10ps
module rofm_factory_model
	import rofm_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       arst_n,
	output rofm_factory_type cfg,
	output logic            valid
);
	logic [3:0] cnt_q;
	// Level bit seven set to show it is cleared for a tree pin
	assign cfg = '{8'hC1, 8'hC0, 4'h7, 4'h5, 1'h0};
	// Slow store read so early accesses meet the loading state
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			cnt_q <= 4'h0;
		else if (cnt_q != 4'hF)
			cnt_q <= cnt_q + 4'h1;
	end
	assign valid = (cnt_q == 4'hF);
endmodule // rofm_factory_model

// >>> test/rofm_rail_override_assertions.sv
// Purpose: Port checks for the rail override block
// Assumes: Pin, kill and fault inputs reach outputs three edges later
// Notes:   up_q marks the first ready, seen only after factory loading
`timescale 1ns/10ps
module rofm_rail_override_assertions
	import rofm_pkg::*;
(
	input wire logic         ref_clk,
	input wire logic         arst_n,
	input wire rofm_req_type reg_req,
	input wire logic [7:0]   reg_rdata,
	input wire logic         reg_ready,
	input wire logic [3:0]   pin_rail_request,
	input wire logic [3:0]   rail_kill_n,
	input wire logic [7:0]   rail_fault,
	input wire logic [3:0]   out_pin_o,
	input wire logic [3:0]   rail_enable,
	input wire logic         fault_shutdown
);
	logic up_q;
	logic acc;
	assign acc = reg_req.wr || reg_req.rd;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			up_q <= 1'h0;
		else if (reg_ready)
			up_q <= 1'h1;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	kill_off_a: assert property (
		(rail_enable & ~$past(rail_kill_n, 3)) == 4'h0) else $error("kill");
	req_on_a: assert property (up_q |-> (~rail_enable &
		$past(pin_rail_request, 3) & $past(rail_kill_n, 3)) == 4'h0)
		else $error("request");
	no_fault_a: assert property (up_q && $past(rail_fault, 3) == 8'h00
		|-> !fault_shutdown) else $error("shutdown");
	ready_a: assert property (up_q && acc |=> reg_ready) else $error("ready");
	ready_cause_a: assert property (reg_ready |-> $past(acc)) else $error("ack");
	unmapped_a: assert property (up_q && reg_req.rd && !reg_req.wr &&
		reg_req.addr != 8'hA1 && reg_req.addr != 8'hA2 |=> reg_rdata == 8'h00)
		else $error("unmapped");
	pin4_od_a: assert property (!out_pin_o[3]) else $error("pin four");
	force_on_a: assert property ((&rail_kill_n)[*3] ##0
		(up_q && reg_req.wr && reg_req.addr == 8'hA1) |=> ##1
		(rail_enable & $past(reg_req.wdata[3:0], 2)) ==
		$past(reg_req.wdata[3:0], 2)) else $error("force");
	cover property (fault_shutdown);
	cover property (&rail_enable);
	cover property (up_q && reg_ready);
endmodule // rofm_rail_override_assertions
bind rofm_rail_override rofm_rail_override_assertions i_chk (.ref_clk,
	.arst_n, .reg_req, .reg_rdata, .reg_ready, .pin_rail_request,
	.rail_kill_n, .rail_fault, .out_pin_o, .rail_enable, .fault_shutdown);

// >>> test/testbench.sv
// Purpose: Register and pin checks of the rail override block
// Assumes: Factory model image C1/C0, push-pull pins one, three
// Notes:   Inputs change 1 ns after the rising edge
`timescale 1ns/10ps
module testbench import rofm_pkg::*;;
	logic ref_clk = 1'h0, arst_n = 1'h0, fv, rdy, got, shut;
	rofm_factory_type fcfg;
	rofm_req_type     req = '0;
	logic [7:0]       rdata, d, fault = 8'h00;
	logic [7:0]       pat [3] = '{8'hFF, 8'h00, 8'h96};
	logic [3:0]       po, poe, ren, rq = 4'h0, kn = 4'hF, pg = 4'h0;
	int               n_mismatch = 0, n_tests = 0, i;
	always #2.5 ref_clk = ~ref_clk;
	rofm_factory_model i_rofm_factory_model (.ref_clk, .arst_n,
		.cfg(fcfg), .valid(fv));
	rofm_rail_override i_rofm_rail_override (.ref_clk, .arst_n,
		.factory_cfg(fcfg), .factory_valid(fv), .reg_req(req),
		.reg_rdata(rdata), .reg_ready(rdy), .pg_tree_level(pg),
		.pin_rail_request(rq), .rail_kill_n(kn), .rail_fault(fault),
		.out_pin_o(po), .out_pin_oe(poe), .rail_enable(ren),
		.fault_shutdown(shut));
	task end_sim;
		if (n_mismatch == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input string n, input logic [7:0] e, s);
		n_tests++;
		if (s !== e) begin
			n_mismatch++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask
	task acc(input logic w, input logic [7:0] a, v);
		@(posedge ref_clk);
		#1 req = '{w, !w, a, v};
		@(posedge ref_clk);
		#1 got = rdy;
		req = '0;
	endtask
	task rd(input logic [7:0] a, e);
		acc(1'h0, a, 8'h00);
		chk("ready", 8'h01, {7'h00, got});
		chk("rdata", e, rdata);
	endtask
	task rail(input logic [3:0] f, r, k);
		rq = r;
		kn = k;
		acc(1'h1, 8'hA1, {4'h0, f});
		repeat (3) @(posedge ref_clk);
		#1 chk("rail", {4'h0, k & (f | r)}, {4'h0, ren});
	endtask
	task flt(input logic [7:0] m, f);
		fault = f;
		acc(1'h1, 8'hA2, m);
		repeat (3) @(posedge ref_clk);
		#1 chk("shut", {7'h00, |(f & ~m)}, {7'h00, shut});
	endtask
	initial begin
		#20000;
		n_mismatch++;
		end_sim;
	end
	initial begin
		repeat (5) @(posedge ref_clk);
		#1 arst_n = 1'h1;
		acc(1'h0, 8'hA1, 8'h00);
		chk("early", 8'h00, {7'h00, got});
		for (i = 0; i < 40 && got !== 1'h1; i++)
			acc(1'h0, 8'hA1, 8'h00);
		chk("load", 8'h41, rdata);
		rd(8'hA2, 8'hC0);
		foreach (pat[j]) begin
			d = pat[j];
			acc(1'h1, 8'hA1, d);
			@(posedge ref_clk);
			#1 chk("o", {5'h00, d[6:4] & 3'h5}, {5'h00, po[2:0]});
			chk("oe", {5'h00, 3'h5 | ~d[6:4]}, {5'h00, poe[2:0]});
			acc(1'h1, 8'hA2, ~d);
			rd(8'hA1, d);
			rd(8'hA2, ~d);
		end
		pg = 4'h8;
		repeat (3) @(posedge ref_clk);
		#1 chk("oe4", 8'h00, {7'h00, poe[3]});
		pg = 4'h0;
		acc(1'h1, 8'hA1, 8'h80);
		repeat (3) @(posedge ref_clk);
		#1 chk("oe4", 8'h01, {7'h00, poe[3]});
		chk("o4", 8'h00, {7'h00, po[3]});
		acc(1'h1, 8'hA3, 8'hFF);
		rd(8'hA3, 8'h00);
		rail(4'hF, 4'h0, 4'hF);
		rail(4'hF, 4'h0, 4'h5);
		rail(4'h0, 4'hA, 4'hF);
		rail(4'h5, 4'hA, 4'h6);
		flt(8'hC0, 8'h80);
		flt(8'h80, 8'h40);
		flt(8'hC0, 8'h01);
		flt(8'h3F, 8'h21);
		flt(8'h00, 8'hFF);
		arst_n = 1'h0;
		#1 chk("reset", 8'h00, {3'h0, shut, ren});
		repeat (2) @(posedge ref_clk);
		#1 arst_n = 1'h1;
		got = 1'h0;
		for (i = 0; i < 40 && got !== 1'h1; i++)
			acc(1'h0, 8'hA1, 8'h00);
		chk("reload", 8'h41, rdata);
		end_sim;
	end
endmodule // testbench
